// ---- logic/tttcu_phase_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
// machine cycle phase generator
module tttcu_phase_gen (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    output logic mc_end_o,
    output logic phase_nine_o,
    output logic phase_ten_o
);
    logic [3:0] phase_q; // current phase, 0 based

    // phase counter wraps after twelve clocks
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_q <= 4'h0;
        end else if (phase_q == tttcu_pkg::PHASE_LAST) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // phase decodes
    assign mc_end_o = (phase_q == tttcu_pkg::PHASE_LAST);
    assign phase_nine_o = (phase_q == tttcu_pkg::PHASE_NINE);
    assign phase_ten_o = (phase_q == tttcu_pkg::PHASE_TEN);
endmodule : tttcu_phase_gen
`default_nettype wire

// ---- logic/tttcu_pkg.sv ----
`default_nettype none
// shared constants of the triple timer/counter unit
package tttcu_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_T01_CTRL = 8'h88; // timer01_control
    localparam logic [7:0] OFF_T2_CTRL = 8'hC8;  // timer2_control
    localparam logic [7:0] OFF_MODE = 8'h8C;     // timer_mode_register
    localparam logic [7:0] OFF_T0_CNT = 8'h90;   // timer 0 high:low bytes
    localparam logic [7:0] OFF_T1_CNT = 8'h94;   // timer 1 high:low bytes
    localparam logic [7:0] OFF_T2_CNT = 8'hCC;   // timer 2 count
    localparam logic [7:0] OFF_T2_CAP = 8'hD0;   // capture high:low bytes
    // timer01_control fields
    localparam int TC_TF1 = 7;
    localparam int TC_TR1 = 6;
    localparam int TC_TF0 = 5;
    localparam int TC_TR0 = 4;
    localparam int TC_IE1 = 3;
    localparam int TC_IT1 = 2;
    localparam int TC_IE0 = 1;
    localparam int TC_IT0 = 0;
    // timer2_control fields
    localparam int T2_TF2 = 7;
    localparam int T2_TIMER_TWO_EXTERNAL_FLAG = 6;
    localparam int T2_RCLK = 5;
    localparam int T2_SERIAL_TX_CLOCK_SELECT = 4;
    localparam int T2_EXEN = 3;
    localparam int T2_TR2 = 2;
    localparam int T2_CT = 1;
    localparam int T2_CPRL = 0;
    // timer_mode_register fields
    localparam int MD_GATE1 = 7;
    localparam int MD_CT1 = 6;
    localparam int MD_SEL1_HI = 5;
    localparam int MD_SEL1_LO = 4;
    localparam int MD_GATE0 = 3;
    localparam int MD_CT0 = 2;
    localparam int MD_SEL0_HI = 1;
    localparam int MD_SEL0_LO = 0;
    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [5:0] RST_SMP = 6'h3F;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // machine cycle phases, 12 clocks each
    localparam logic [3:0] PHASE_LAST = 4'hB;
    localparam logic [3:0] PHASE_NINE = 4'h8;
    localparam logic [3:0] PHASE_TEN = 4'h9;
    // sampled pin vector positions
    localparam int PIN_EXT0 = 0;
    localparam int PIN_EXT1 = 1;
    localparam int PIN_T0 = 2;
    localparam int PIN_T1 = 3;
    localparam int PIN_T2 = 4;
    localparam int PIN_TRIG = 5;
    // timer 0/1 operating modes, in select-bit order
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD8,
        MODE_SPLIT
    } tttcu_mode_type;
endpackage : tttcu_pkg
`default_nettype wire

// ---- logic/tttcu_top.sv ----
// Contract
// - timer mode counts once per machine cycle
// - overflow sets flag, vector acknowledge clears it
// - run bits switch timers 0 and 1
// - edge flags set on edge, cleared when serviced
// - type bits choose falling edge or low level
// - counter mode counts sampled falling pin edges
// - edge takes two machine cycles to record
// - mode 0 is 13-bit with 5-bit prescaler
// - count only when run and gate allows
// - mode 1 is plain 16-bit counter
// - mode 2 reloads low from high byte
// - mode 3 stops timer 1, splits timer 0
// - split high byte uses timer 1 controls
// - timer 2 counts cycles or pin edges
// - timer 2 flag blocked under serial clocking
// - trigger flag set on capture or reload
// - serial clocks pick timer 2 or 1
// - trigger enable gates the trigger pin
// - timer 2 run bit stops everything
// - capture copies count on trigger edge
// - reload on overflow or trigger edge
// - two select bits choose the mode
// - select bit picks counter or timer
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module tttcu_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic ext_irq_zero_pin_i,
    input wire logic ext_irq_one_pin_i,
    input wire logic timer_zero_event_pin_i,
    input wire logic timer_one_event_pin_i,
    input wire logic timer_two_event_pin_i,
    input wire logic capture_trigger_pin_i,
    input wire logic timer_zero_ack_i,
    input wire logic timer_one_ack_i,
    input wire logic ext_irq_zero_ack_i,
    input wire logic ext_irq_one_ack_i,
    output logic timer_zero_irq_o,
    output logic timer_one_irq_o,
    output logic timer_two_irq_o,
    output logic ext_irq_zero_irq_o,
    output logic ext_irq_one_irq_o,
    output logic serial_rx_clock_o,
    output logic serial_tx_clock_o
);
    // decode helpers
    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
        return en && (a == off);
    endfunction : wr_hit

    // counting allowed while run and either no pin qualify or pin high
    function automatic logic gate_open(input logic run, input logic qualify, input logic pin);
        return run && (!qualify || pin);
    endfunction : gate_open

    // one increment of a timer 0/1, returns {overflow, high, low}
    function automatic logic [16:0] tmr_step(input tttcu_pkg::tttcu_mode_type mode,
                                             input logic [7:0] lo, input logic [7:0] hi);
        logic [12:0] c13;
        logic [12:0] n13;
        logic [16:0] r;
        c13 = {hi, lo[4:0]};
        n13 = c13 + 13'h0001;
        r = 17'h00000;
        unique case (mode)
            tttcu_pkg::MODE_13BIT: begin
                r = {(&c13), n13[12:5], lo[7:5], n13[4:0]};
            end
            tttcu_pkg::MODE_16BIT: begin
                r = {(&{hi, lo}), {hi, lo} + 16'h0001};
            end
            tttcu_pkg::MODE_RELOAD8: begin
                r = {(&lo), hi, ((&lo) ? hi : lo + 8'h01)};
            end
            tttcu_pkg::MODE_SPLIT: begin
                r = {(&lo), hi, lo + 8'h01};
            end
        endcase
        return r;
    endfunction : tmr_step

    logic mc_end; // last clock of machine cycle
    logic ph_nine; // phase nine strobe
    logic ph_ten; // phase ten strobe
    logic [5:0] pin_vec; // all sampled pins
    logic [5:0] smp_en; // per pin sample strobe
    logic [5:0] smp_q; // last sampled level
    logic [5:0] fall_now; // falling edge seen this sample
    logic [5:0] fall_q; // edge held until next sample
    logic wr_q; // write data phase pending
    logic rd_pend_q; // read wait state
    logic [7:0] addr_q; // latched address
    logic [31:0] hrdata_q; // read data register
    logic [31:0] rd_mux; // read selection
    logic addr_ok; // address phase taken
    logic wr_tc, wr_t2c, wr_md, wr_c0, wr_c1, wr_c2, wr_cap; // write strobes
    logic [7:0] timer01_control_q, timer01_control_d; // timer01_control
    logic [7:0] timer2_control_q, timer2_control_d; // timer2_control
    logic [7:0] timer_mode_q; // timer_mode_register
    logic [7:0] t0_low_q, t0_high_q; // timer 0 bytes
    logic [7:0] t1_low_q, t1_high_q; // timer 1 bytes
    logic [15:0] t2_count_q; // timer 2 count
    logic [15:0] capture_q; // capture high:low bytes
    tttcu_pkg::tttcu_mode_type mode0, mode1; // decoded modes
    logic split; // timer 0 in mode 3
    logic en0, en1, tick0, tick1, inc0, inc1; // timer 0/1 advance
    logic [16:0] step0, step1; // next values
    logic ovf0, ovf1, inc_hi0, ovf_hi0; // overflow pulses and split high byte increment
    logic tf0_set, tf1_set; // flag set terms
    logic baud, tick2, inc2, ovf2, trig_evt; // timer 2 terms
    logic ser_rx_q, ser_tx_q; // serial clock pulses

    // machine cycle timing
    tttcu_phase_gen u_phase (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .mc_end_o(mc_end),
        .phase_nine_o(ph_nine),
        .phase_ten_o(ph_ten)
    );

    // pin sampling: timers 0/1 and ext pins at phase ten, timer 2 pins at phase nine
    assign pin_vec = {capture_trigger_pin_i, timer_two_event_pin_i, timer_one_event_pin_i,
                      timer_zero_event_pin_i, ext_irq_one_pin_i, ext_irq_zero_pin_i};
    assign smp_en = {ph_nine, ph_nine, ph_ten, ph_ten, ph_ten, ph_ten};
    assign fall_now = smp_en & smp_q & ~pin_vec;

    // sample registers and held edges
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            smp_q <= tttcu_pkg::RST_SMP;
            fall_q <= 6'h00;
        end else begin
            smp_q <= (smp_en & pin_vec) | (~smp_en & smp_q);
            fall_q <= fall_now | (~smp_en & fall_q);
        end
    end

    // bus address phase and wait state
    assign addr_ok = hsel_i && hready_i && htrans_i[1];
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= tttcu_pkg::RST_BYTE;
        end else begin
            wr_q <= addr_ok && hwrite_i;
            rd_pend_q <= addr_ok && !hwrite_i;
            if (addr_ok) begin
                addr_q <= haddr_i[7:0];
            end
        end
    end

    // write strobes in the data phase
    assign wr_tc = wr_hit(wr_q, addr_q, tttcu_pkg::OFF_T01_CTRL);
    assign wr_t2c = wr_hit(wr_q, addr_q, tttcu_pkg::OFF_T2_CTRL);
    assign wr_md = wr_hit(wr_q, addr_q, tttcu_pkg::OFF_MODE);
    assign wr_c0 = wr_hit(wr_q, addr_q, tttcu_pkg::OFF_T0_CNT);
    assign wr_c1 = wr_hit(wr_q, addr_q, tttcu_pkg::OFF_T1_CNT);
    assign wr_c2 = wr_hit(wr_q, addr_q, tttcu_pkg::OFF_T2_CNT);
    assign wr_cap = wr_hit(wr_q, addr_q, tttcu_pkg::OFF_T2_CAP);

    // read selection, unmapped reads zero
    always_comb begin
        unique case (addr_q)
            tttcu_pkg::OFF_T01_CTRL: rd_mux = {24'h000000, timer01_control_q};
            tttcu_pkg::OFF_T2_CTRL: rd_mux = {24'h000000, timer2_control_q};
            tttcu_pkg::OFF_MODE: rd_mux = {24'h000000, timer_mode_q};
            tttcu_pkg::OFF_T0_CNT: rd_mux = {16'h0000, t0_high_q, t0_low_q};
            tttcu_pkg::OFF_T1_CNT: rd_mux = {16'h0000, t1_high_q, t1_low_q};
            tttcu_pkg::OFF_T2_CNT: rd_mux = {16'h0000, t2_count_q};
            tttcu_pkg::OFF_T2_CAP: rd_mux = {16'h0000, capture_q};
            default: rd_mux = tttcu_pkg::RST_WORD;
        endcase
    end

    // read data captured during the wait state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hrdata_q <= tttcu_pkg::RST_WORD;
        end else if (rd_pend_q) begin
            hrdata_q <= rd_mux;
        end
    end
    assign hrdata_o = hrdata_q;
    assign hreadyout_o = !rd_pend_q;
    assign hresp_o = 1'b0;

    // mode register, software only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_mode_q <= tttcu_pkg::RST_BYTE;
        end else if (wr_md) begin
            timer_mode_q <= hwdata_i[7:0];
        end
    end
    assign mode0 = tttcu_pkg::tttcu_mode_type'(timer_mode_q[tttcu_pkg::MD_SEL0_HI:tttcu_pkg::MD_SEL0_LO]);
    assign mode1 = tttcu_pkg::tttcu_mode_type'(timer_mode_q[tttcu_pkg::MD_SEL1_HI:tttcu_pkg::MD_SEL1_LO]);
    assign split = (mode0 == tttcu_pkg::MODE_SPLIT);

    // timer 0 advance terms
    assign en0 = gate_open(timer01_control_q[tttcu_pkg::TC_TR0], timer_mode_q[tttcu_pkg::MD_GATE0], ext_irq_zero_pin_i);
    assign tick0 = timer_mode_q[tttcu_pkg::MD_CT0] ? fall_q[tttcu_pkg::PIN_T0] : 1'b1;
    assign inc0 = mc_end && en0 && tick0;
    assign step0 = tmr_step(mode0, t0_low_q, t0_high_q);
    assign ovf0 = inc0 && step0[16];
    assign inc_hi0 = split && mc_end && timer01_control_q[tttcu_pkg::TC_TR1];
    assign ovf_hi0 = inc_hi0 && (&t0_high_q);

    // timer 1 advance terms, held in mode 3
    assign en1 = gate_open(timer01_control_q[tttcu_pkg::TC_TR1] && (mode1 != tttcu_pkg::MODE_SPLIT),
                           timer_mode_q[tttcu_pkg::MD_GATE1], ext_irq_one_pin_i);
    assign tick1 = timer_mode_q[tttcu_pkg::MD_CT1] ? fall_q[tttcu_pkg::PIN_T1] : 1'b1;
    assign inc1 = mc_end && en1 && tick1;
    assign step1 = tmr_step(mode1, t1_low_q, t1_high_q);
    assign ovf1 = inc1 && step1[16];

    // overflow flag sources; split high byte owns timer 1 flag
    assign tf0_set = ovf0;
    assign tf1_set = split ? ovf_hi0 : ovf1;

    // timer 0 counter, bus write wins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            t0_low_q <= tttcu_pkg::RST_BYTE;
            t0_high_q <= tttcu_pkg::RST_BYTE;
        end else if (wr_c0) begin
            t0_low_q <= hwdata_i[7:0];
            t0_high_q <= hwdata_i[15:8];
        end else begin
            if (inc0) begin
                t0_low_q <= step0[7:0];
            end
            if (split) begin
                if (inc_hi0) begin
                    t0_high_q <= t0_high_q + 8'h01;
                end
            end else if (inc0) begin
                t0_high_q <= step0[15:8];
            end
        end
    end

    // timer 1 counter, bus write wins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            t1_low_q <= tttcu_pkg::RST_BYTE;
            t1_high_q <= tttcu_pkg::RST_BYTE;
        end else if (wr_c1) begin
            t1_low_q <= hwdata_i[7:0];
            t1_high_q <= hwdata_i[15:8];
        end else if (inc1) begin
            t1_low_q <= step1[7:0];
            t1_high_q <= step1[15:8];
        end
    end

    // timer01_control next value: write, then clears, then hardware sets
    always_comb begin
        timer01_control_d = wr_tc ? hwdata_i[7:0] : timer01_control_q;
        if (!wr_tc && timer_one_ack_i) begin
            timer01_control_d[tttcu_pkg::TC_TF1] = 1'b0;
        end
        if (!wr_tc && timer_zero_ack_i) begin
            timer01_control_d[tttcu_pkg::TC_TF0] = 1'b0;
        end
        if (tf1_set) begin
            timer01_control_d[tttcu_pkg::TC_TF1] = 1'b1;
        end
        if (tf0_set) begin
            timer01_control_d[tttcu_pkg::TC_TF0] = 1'b1;
        end
        // external interrupt 1: edge latch or level follow
        if (timer01_control_q[tttcu_pkg::TC_IT1]) begin
            if (!wr_tc && ext_irq_one_ack_i) begin
                timer01_control_d[tttcu_pkg::TC_IE1] = 1'b0;
            end
            if (fall_now[tttcu_pkg::PIN_EXT1]) begin
                timer01_control_d[tttcu_pkg::TC_IE1] = 1'b1;
            end
        end else begin
            timer01_control_d[tttcu_pkg::TC_IE1] = !smp_q[tttcu_pkg::PIN_EXT1];
        end
        // external interrupt 0: edge latch or level follow
        if (timer01_control_q[tttcu_pkg::TC_IT0]) begin
            if (!wr_tc && ext_irq_zero_ack_i) begin
                timer01_control_d[tttcu_pkg::TC_IE0] = 1'b0;
            end
            if (fall_now[tttcu_pkg::PIN_EXT0]) begin
                timer01_control_d[tttcu_pkg::TC_IE0] = 1'b1;
            end
        end else begin
            timer01_control_d[tttcu_pkg::TC_IE0] = !smp_q[tttcu_pkg::PIN_EXT0];
        end
    end

    // timer01_control register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer01_control_q <= tttcu_pkg::RST_BYTE;
        end else begin
            timer01_control_q <= timer01_control_d;
        end
    end

    // timer 2 terms
    assign baud = timer2_control_q[tttcu_pkg::T2_RCLK] || timer2_control_q[tttcu_pkg::T2_SERIAL_TX_CLOCK_SELECT];
    assign tick2 = timer2_control_q[tttcu_pkg::T2_CT] ? fall_q[tttcu_pkg::PIN_T2] : 1'b1;
    assign inc2 = mc_end && timer2_control_q[tttcu_pkg::T2_TR2] && tick2;
    assign ovf2 = inc2 && (&t2_count_q);
    assign trig_evt = fall_now[tttcu_pkg::PIN_TRIG] && timer2_control_q[tttcu_pkg::T2_EXEN] &&
                      !baud && timer2_control_q[tttcu_pkg::T2_TR2];

    // timer 2 counter: write, trigger reload, overflow reload, count
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            t2_count_q <= tttcu_pkg::RST_CNT;
        end else if (wr_c2) begin
            t2_count_q <= hwdata_i[15:0];
        end else if (trig_evt && !timer2_control_q[tttcu_pkg::T2_CPRL]) begin
            t2_count_q <= capture_q;
        end else if (ovf2 && (baud || !timer2_control_q[tttcu_pkg::T2_CPRL])) begin
            t2_count_q <= capture_q;
        end else if (inc2) begin
            t2_count_q <= t2_count_q + 16'h0001;
        end
    end

    // capture register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            capture_q <= tttcu_pkg::RST_CNT;
        end else if (wr_cap) begin
            capture_q <= hwdata_i[15:0];
        end else if (trig_evt && timer2_control_q[tttcu_pkg::T2_CPRL]) begin
            capture_q <= t2_count_q;
        end
    end

    // timer2_control next value, hardware set wins
    always_comb begin
        timer2_control_d = wr_t2c ? hwdata_i[7:0] : timer2_control_q;
        if (ovf2 && !baud) begin
            timer2_control_d[tttcu_pkg::T2_TF2] = 1'b1;
        end
        if (trig_evt) begin
            timer2_control_d[tttcu_pkg::T2_TIMER_TWO_EXTERNAL_FLAG] = 1'b1;
        end
    end

    // timer2_control register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer2_control_q <= tttcu_pkg::RST_BYTE;
        end else begin
            timer2_control_q <= timer2_control_d;
        end
    end

    // serial port clock pulses
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ser_rx_q <= 1'b0;
            ser_tx_q <= 1'b0;
        end else begin
            ser_rx_q <= timer2_control_q[tttcu_pkg::T2_RCLK] ? ovf2 : ovf1;
            ser_tx_q <= timer2_control_q[tttcu_pkg::T2_SERIAL_TX_CLOCK_SELECT] ? ovf2 : ovf1;
        end
    end

    // interrupt requests from flags
    assign timer_zero_irq_o = timer01_control_q[tttcu_pkg::TC_TF0];
    assign timer_one_irq_o = timer01_control_q[tttcu_pkg::TC_TF1];
    assign ext_irq_zero_irq_o = timer01_control_q[tttcu_pkg::TC_IE0];
    assign ext_irq_one_irq_o = timer01_control_q[tttcu_pkg::TC_IE1];
    assign timer_two_irq_o = timer2_control_q[tttcu_pkg::T2_TF2] || timer2_control_q[tttcu_pkg::T2_TIMER_TWO_EXTERNAL_FLAG];
    assign serial_rx_clock_o = ser_rx_q;
    assign serial_tx_clock_o = ser_tx_q;

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_MC_PERIOD: assert property (mc_end |=> !mc_end [*8] ##1 !mc_end ##1 !mc_end ##1 !mc_end ##1 mc_end)
        else $error("machine cycle is not twelve clocks");
    AST_T0_INC16: assert property ((inc0 && mode0 == tttcu_pkg::MODE_16BIT && !wr_c0)
        |=> {t0_high_q, t0_low_q} == $past({t0_high_q, t0_low_q}) + 16'h0001)
        else $error("timer 0 mode 1 did not step by one");
    AST_TF0_SET: assert property (ovf0 |=> timer01_control_q[tttcu_pkg::TC_TF0])
        else $error("timer 0 overflow flag not set");
    AST_TF1_ACK: assert property ((timer01_control_q[tttcu_pkg::TC_TF1] && timer_one_ack_i && !tf1_set && !wr_tc)
        |=> !timer01_control_q[tttcu_pkg::TC_TF1])
        else $error("timer 1 flag not cleared on acknowledge");
    AST_T0_STOPPED: assert property ((!timer01_control_q[tttcu_pkg::TC_TR0] && !split && !wr_c0)
        |=> $stable({t0_high_q, t0_low_q}))
        else $error("timer 0 moved while run bit low");
    AST_EXT0_EDGE: assert property ((timer01_control_q[tttcu_pkg::TC_IT0] && fall_now[tttcu_pkg::PIN_EXT0])
        |=> timer01_control_q[tttcu_pkg::TC_IE0])
        else $error("edge flag 0 not set on falling edge");
    AST_T0_GATED: assert property ((timer_mode_q[tttcu_pkg::MD_GATE0] && !ext_irq_zero_pin_i && !wr_c0)
        |=> $stable(t0_low_q))
        else $error("timer 0 counted with gate pin low");
    AST_MODE2_RELOAD: assert property ((ovf0 && mode0 == tttcu_pkg::MODE_RELOAD8 && !wr_c0)
        |=> t0_low_q == $past(t0_high_q) && $stable(t0_high_q))
        else $error("mode 2 reload did not copy high byte");
    AST_T1_MODE3_HOLD: assert property ((mode1 == tttcu_pkg::MODE_SPLIT && !wr_c1)
        |=> $stable({t1_high_q, t1_low_q}))
        else $error("timer 1 counted in mode 3");
    AST_TF2_BLOCKED: assert property ((baud && !timer2_control_q[tttcu_pkg::T2_TF2] && !wr_t2c)
        |=> !timer2_control_q[tttcu_pkg::T2_TF2])
        else $error("timer 2 flag set while serial clocking");
    AST_CAPTURE: assert property ((trig_evt && timer2_control_q[tttcu_pkg::T2_CPRL] && !wr_cap)
        |=> capture_q == $past(t2_count_q) && timer2_control_q[tttcu_pkg::T2_TIMER_TWO_EXTERNAL_FLAG])
        else $error("capture did not take the count");
    AST_T2_OFF: assert property ((!timer2_control_q[tttcu_pkg::T2_TR2] && !wr_c2) |=> $stable(t2_count_q))
        else $error("timer 2 moved while stopped");
endmodule : tttcu_top
`default_nettype wire

// ---- tb/triple_timer_counter_unit_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module triple_timer_counter_unit_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] ack = 4'h0; // vector acks: t0, t1, e0, e1
    logic [5:0] want = 6'h3F; // pin levels asked of the far side
    wire logic [5:0] pin;
    wire logic hrdy;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [6:0] irq; // t0, t1, t2, e0, e1, rx clk, tx clk
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'h430F;
    logic [31:0] r;
    logic [31:0] d;
    logic [15:0] st [3] = '{16'hFF1F, 16'hFFFF, 16'h80FF}; // start counts, modes 0..2
    logic [15:0] ex [3] = '{16'h0000, 16'h0000, 16'h8080}; // counts after overflow
    always #2 sys_clk = ~sys_clk;
    tttcu_top DUT (.sys_clk_i(sys_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
        .hresp_o(hresp), .hrdata_o(hrdata), .ext_irq_zero_pin_i(pin[0]), .ext_irq_one_pin_i(pin[1]),
        .timer_zero_event_pin_i(pin[2]), .timer_one_event_pin_i(pin[3]), .timer_two_event_pin_i(pin[4]),
        .capture_trigger_pin_i(pin[5]), .timer_zero_ack_i(ack[0]), .timer_one_ack_i(ack[1]),
        .ext_irq_zero_ack_i(ack[2]), .ext_irq_one_ack_i(ack[3]), .timer_zero_irq_o(irq[0]),
        .timer_one_irq_o(irq[1]), .timer_two_irq_o(irq[2]), .ext_irq_zero_irq_o(irq[3]),
        .ext_irq_one_irq_o(irq[4]), .serial_rx_clock_o(irq[5]), .serial_tx_clock_o(irq[6]));
    tttcu_pin_model PM (.sys_clk_i(sys_clk), .want_i(want), .pin_o(pin));
    // one single word transfer, read data left in r
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge sys_clk); while (hrdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge sys_clk); while (hrdy !== 1'b1);
        r = hrdata;
        `CHK("resp", 1'b0, hresp)
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK("rdata", e, r)
    endtask : rd
    // one-cycle vector acknowledge
    task ak(input int b);
        @(posedge sys_clk); ack[b] <= 1'b1;
        @(posedge sys_clk); ack[b] <= 1'b0;
    endtask : ak
    // bounded wait for an output level
    task wfor(input int b, input logic v, input int n);
        int k;
        k = 0;
        while (irq[b] !== v && k < n) begin @(posedge sys_clk); k++; end
        `CHK("irq", v, irq[b])
    endtask : wfor
    task wrap_up;
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h88, 32'h0);
        rd(8'hC8, 32'h0);
        bus(1'b1, 8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            bus(1'b1, 8'hD0, d);
            rd(8'hD0, {16'h0, d[15:0]});
        end
        // modes 0..2 overflow, flag and ack
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, 8'h8C, m); bus(1'b1, 8'h90, st[m]); bus(1'b1, 8'h88, 32'h10);
            wfor(0, 1'b1, 60);
            ak(0); wfor(0, 1'b0, 4);
            bus(1'b1, 8'h88, 32'h0); rd(8'h90, {16'h0, ex[m]});
        end
        // split mode: high byte on timer 1 run, timer 1 frozen
        bus(1'b1, 8'h8C, 32'h33); bus(1'b1, 8'h90, 32'hFF00); bus(1'b1, 8'h94, d);
        bus(1'b1, 8'h88, 32'h40);
        wfor(1, 1'b1, 60);
        rd(8'h94, {16'h0, d[15:0]});
        ak(1); bus(1'b1, 8'h88, 32'h0);
        // gate pin holds the count
        bus(1'b1, 8'h8C, 32'h09); want[0] <= 1'b0; repeat (30) @(posedge sys_clk);
        bus(1'b1, 8'h90, 32'hFFFF); bus(1'b1, 8'h88, 32'h10); repeat (40) @(posedge sys_clk);
        `CHK("irq", 1'b0, irq[0])
        want[0] <= 1'b1; wfor(0, 1'b1, 80);
        ak(0); bus(1'b1, 8'h88, 32'h01); repeat (30) @(posedge sys_clk);
        // edge then level external interrupt
        want[1:0] <= 2'b00; wfor(3, 1'b1, 60);
        wfor(4, 1'b1, 30);
        ak(2); wfor(3, 1'b0, 4);
        bus(1'b1, 8'h88, 32'h0); wfor(3, 1'b1, 30);
        want[1:0] <= 2'b11; wfor(3, 1'b0, 60);
        wfor(4, 1'b0, 30);
        // counter operation on the event pin
        bus(1'b1, 8'h8C, 32'h05); bus(1'b1, 8'h90, 32'hFFFF); bus(1'b1, 8'h88, 32'h10);
        repeat (40) @(posedge sys_clk);
        `CHK("irq", 1'b0, irq[0])
        want[2] <= 1'b0; wfor(0, 1'b1, 80);
        ak(0); bus(1'b1, 8'h88, 32'h0);
        // timer 2 overflow reload, then serial clocking
        bus(1'b1, 8'hD0, 32'h1234); bus(1'b1, 8'hCC, 32'hFFFF); bus(1'b1, 8'hC8, 32'h04);
        wfor(2, 1'b1, 40);
        rd(8'hCC, 32'h1234);
        rd(8'hC8, 32'h84);
        bus(1'b1, 8'hC8, 32'h34); bus(1'b1, 8'hCC, 32'hFFFF);
        wfor(6, 1'b1, 40);
        `CHK("rx", 1'b1, irq[5])
        `CHK("irq", 1'b0, irq[2])
        // trigger edge captures a held count in counter mode
        d = $random(seed);
        bus(1'b1, 8'hC8, 32'h0F); bus(1'b1, 8'hCC, d); want[5] <= 1'b0;
        wfor(2, 1'b1, 60);
        rd(8'hD0, {16'h0, d[15:0]});
        rd(8'hC8, 32'h4F);
        wrap_up;
    end
endmodule : triple_timer_counter_unit_bench
`default_nettype wire

// ---- tb/tttcu_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// far-side pins, each level held two machine cycles
module tttcu_pin_model (
    input wire logic sys_clk_i,
    input wire logic [5:0] want_i,
    output logic [5:0] pin_o
);
    logic [4:0] held_q = 5'h00; // clocks since last change
    initial pin_o = 6'h3F;
    // move pins only once the hold span ran out
    always @(posedge sys_clk_i) begin
        if (held_q != 5'h18) begin
            held_q <= held_q + 5'h01;
        end else if (want_i != pin_o) begin
            pin_o <= want_i;
            held_q <= 5'h00;
        end
    end
endmodule : tttcu_pin_model
`default_nettype wire
